//--- verilog/amp_prot_cfg.svh
`ifndef AMP_PROT_CFG_SVH
`define AMP_PROT_CFG_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
// DC shutdown control, error handler control and fault status offsets.
`define REG_DC_SHUTDOWN_CONTROL 7'h26
`define REG_ERROR_HANDLER_CONTROL 7'h2d
`define REG_FAULT_STATUS 7'h7c
// Last read/write address (80) and first read-only address (96).
`define RW_LAST_ADDR 7'h50
`define RO_FIRST_ADDR 7'h60
// Register bank depth in byte entries (128).
`define REG_BANK_DEPTH 128

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define DCCTL_ENABLE_BIT 2
`define DCCTL_RESET 8'h04
`define EHCTL_NO_RESTART_BIT 1
`define EHCTL_CLEAR_BIT 2
`define EHCTL_RESET 8'h00
`define STAT_OC_BIT 0
`define STAT_SHORT_BIT 1
`define STAT_DC_BIT 2
`define STAT_PIN_BIT 3
`define STAT_TW_BIT 4
`define STAT_TE_BIT 5
`define STAT_UV_BIT 6

// ---------------------------------------------------------------
// Thresholds: temperature in degrees C, supplies in tenths of a volt
// ---------------------------------------------------------------
`define TE_SET_C 8'h96
`define TE_CLR_C 8'h87
`define TW_SET_C 8'h7d
`define TW_CLR_C 8'h69
`define LOGIC_RISE_DV 8'h2a
`define LOGIC_FALL_DV 8'h28
`define PSTAGE_RISE_DV 8'h2b
`define PSTAGE_FALL_DV 8'h29

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_MHZ 250
`define DC_QUAL_MS 700
`define OC_RESTART_US 1000
`define PIN_CHECK_NS 1000

`endif

//--- verilog/amp_prot_pkg.sv
`default_nettype none

package amp_prot_pkg;

  // ---------------------------------------------------------------
  // Power stage sequencing states
  // ---------------------------------------------------------------
  // Off, pin-to-pin short check, switching, and shut down after a current fault.
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN = 2'b10,
    ST_HOLD = 2'b11
  } stage_state_type;

endpackage

`default_nettype wire

//--- verilog/regbank_if.sv
`default_nettype none

// ---------------------------------------------------------------
// Link between the protection core and its register bank memory
// ---------------------------------------------------------------
interface regbank_if #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
);
  logic wr; // Write strobe, one cycle.
  logic rd; // Read strobe, one cycle.
  logic [ADDR_W-1:0] addr; // Entry address.
  logic [DATA_W-1:0] wdata; // Write data.
  logic [DATA_W-1:0] rdata; // Registered read data, valid one cycle after rd.

  modport ctrl (output wr, output rd, output addr, output wdata, input rdata);
  modport mem (input wr, input rd, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

//--- verilog/register_bank.sv
`default_nettype none

module register_bank #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  regbank_if.mem bus
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Plain byte entries; no reset, software sets what it uses.
  logic [WIDTH-1:0] mem [DEPTH];
  // Read data leaves through a register so the caller sees a fixed latency.
  logic [WIDTH-1:0] rdata_q;

  if (DEPTH < 2 || DEPTH > (1 << $bits(bus.addr))) begin : g_depth_chk
    $error("register_bank depth does not fit the address width");
  end

  // Write and registered read, both frozen while the clock enable is low.
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (bus.wr) begin
        mem[bus.addr] <= bus.wdata;
      end
      if (sys_rst) begin
        rdata_q <= '0;
      end else if (bus.rd) begin
        rdata_q <= mem[bus.addr];
      end
    end
  end

  assign bus.rdata = rdata_q;

endmodule

`default_nettype wire

//--- verilog/amplifier_fault_protection.sv
`default_nettype none
`include "amp_prot_cfg.svh"

module amplifier_fault_protection #(
  parameter int NUM_SWITCHES = 4,
  parameter int NUM_OUTPUTS = 4,
  parameter int DC_QUAL_CYCLES = `DC_QUAL_MS * 1000 * `CLK_MHZ,
  parameter int RESTART_CYCLES = `OC_RESTART_US * `CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic enable_n,
  input wire logic [NUM_SWITCHES-1:0] oc_raw,
  input wire logic [NUM_SWITCHES-1:0] switch_on,
  input wire logic out_short_raw,
  input wire logic pin_short_raw,
  input wire logic [NUM_OUTPUTS-1:0] dc_high_raw,
  input wire logic [NUM_OUTPUTS-1:0] dc_low_raw,
  input wire logic [7:0] temp_celsius,
  input wire logic [7:0] power_stage_supply_dv,
  input wire logic [7:0] digital_supply_dv,
  input wire logic [7:0] analog_supply_dv,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic stage_enable,
  output logic current_limit,
  output logic fault_n
);

  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  // Pin check time rounds up to whole cycles.
  localparam int PIN_CHECK_CYCLES = (`PIN_CHECK_NS * `CLK_MHZ + 999) / 1000;
  localparam logic [17:0] RESTART_LAST = 18'(RESTART_CYCLES - 1);
  localparam logic [17:0] PIN_LAST = 18'(PIN_CHECK_CYCLES - 1);
  localparam logic [27:0] DC_QUAL = 28'(DC_QUAL_CYCLES);

  if (RESTART_CYCLES < 1 || RESTART_CYCLES > 262143 || DC_QUAL_CYCLES < 1 ||
      DC_QUAL_CYCLES > 268435454 || NUM_SWITCHES < 1 || NUM_OUTPUTS < 1) begin : g_chk
    $error("amplifier_fault_protection parameters out of range");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_SWITCHES-1:0] oc_s1; // First synchroniser stages.
    logic [NUM_SWITCHES-1:0] oc_s2; // Second synchroniser stages.
    logic [NUM_OUTPUTS-1:0] hi_s1;
    logic [NUM_OUTPUTS-1:0] hi_s2;
    logic [NUM_OUTPUTS-1:0] lo_s1;
    logic [NUM_OUTPUTS-1:0] lo_s2;
    logic [2:0] misc_s1; // Enable, output short, pin short.
    logic [2:0] misc_s2;
    logic [NUM_OUTPUTS-1:0][27:0] dc_cnt; // Per-output offset duration.
    amp_prot_pkg::stage_state_type state;
    logic [17:0] timer; // Pin check and restart delay.
    logic [7:0] dcctl; // DC shutdown control register.
    logic [7:0] ehctl; // Error handler control register.
    logic tw; // Thermal warning with hysteresis.
    logic te; // Thermal error with hysteresis.
    logic pv_ok; // Power stage supply above lockout.
    logic dv_ok; // Digital supply above lockout.
    logic av_ok; // Analog supply above lockout.
    logic oc_flag; // Sticky over-current.
    logic short_flag; // Sticky output short.
    logic pin_flag; // Sticky pin-to-pin short.
    logic dc_flag; // Sticky DC fault.
    logic rd_pend; // Read issued last cycle.
    logic [6:0] rd_addr; // Address of the pending read.
    logic [7:0] rdata;
    logic rvalid;
    logic stage_en;
    logic cur_lim;
    logic fault_n;
  } core_state_type;

  core_state_type q;
  core_state_type d;
  regbank_if #(.ADDR_W(7), .DATA_W(8)) rb ();

  // Combinational views used below and by the checks.
  logic enabled;
  logic clear_evt;
  logic clear_all;
  logic uv_ok;
  logic run_ok;
  logic dc_hit;
  logic [NUM_SWITCHES-1:0] oc_hits;
  logic [7:0] status;

  // ---------------------------------------------------------------
  // Register bank memory
  // ---------------------------------------------------------------
  // Only the writable range reaches the memory; read-only space is never stored.
  assign rb.wr = reg_wr && (reg_addr <= `RW_LAST_ADDR);
  assign rb.rd = reg_rd;
  assign rb.addr = reg_addr;
  assign rb.wdata = reg_wdata;

  register_bank #(.DEPTH(`REG_BANK_DEPTH), .WIDTH(8)) u_bank (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .bus(rb.mem)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // One pass computes every flag first, then the sequencer from those new flags,
  // so the stage enable never lags a fault by a cycle.
  always_comb begin
    d = q;
    d.oc_s1 = oc_raw;
    d.oc_s2 = q.oc_s1;
    d.hi_s1 = dc_high_raw;
    d.hi_s2 = q.hi_s1;
    d.lo_s1 = dc_low_raw;
    d.lo_s2 = q.lo_s1;
    d.misc_s1 = {enable_n, out_short_raw, pin_short_raw};
    d.misc_s2 = q.misc_s1;
    enabled = !q.misc_s2[2];

    // Register writes; a change of the clear bit is the toggle that clears.
    clear_evt = 1'b0;
    if (reg_wr && reg_addr == `REG_DC_SHUTDOWN_CONTROL) begin
      d.dcctl = reg_wdata;
    end
    if (reg_wr && reg_addr == `REG_ERROR_HANDLER_CONTROL) begin
      d.ehctl = reg_wdata;
      clear_evt = reg_wdata[`EHCTL_CLEAR_BIT] != q.ehctl[`EHCTL_CLEAR_BIT];
    end
    // Holding the chip disabled acts as a continuous clear.
    clear_all = clear_evt || !enabled;

    // Thermal comparators with hysteresis.
    d.te = q.te ? (temp_celsius > `TE_CLR_C) : (temp_celsius >= `TE_SET_C);
    d.tw = q.tw ? (temp_celsius > `TW_CLR_C) : (temp_celsius >= `TW_SET_C);

    // Supply lockout with rising and falling levels; digital and analog supplies share the logic levels.
    d.pv_ok = q.pv_ok ? (power_stage_supply_dv > `PSTAGE_FALL_DV) : (power_stage_supply_dv >= `PSTAGE_RISE_DV);
    d.dv_ok = q.dv_ok ? (digital_supply_dv > `LOGIC_FALL_DV) : (digital_supply_dv >= `LOGIC_RISE_DV);
    d.av_ok = q.av_ok ? (analog_supply_dv > `LOGIC_FALL_DV) : (analog_supply_dv >= `LOGIC_RISE_DV);
    uv_ok = d.pv_ok && d.dv_ok && d.av_ok;

    // Only switches that are conducting can report a valid over-current.
    oc_hits = (q.state == amp_prot_pkg::ST_RUN) ? (q.oc_s2 & switch_on) : '0;

    // Offset timers run only while switching with DC protection enabled.
    dc_hit = 1'b0;
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      if (q.dcctl[`DCCTL_ENABLE_BIT] && q.state == amp_prot_pkg::ST_RUN &&
          (q.hi_s2[i] || q.lo_s2[i])) begin
        d.dc_cnt[i] = (q.dc_cnt[i] > DC_QUAL) ? q.dc_cnt[i] : q.dc_cnt[i] + 28'h1;
      end else begin
        d.dc_cnt[i] = '0;
      end
      // The offset must persist beyond the full qualification time.
      dc_hit = dc_hit || (q.dc_cnt[i] > DC_QUAL);
    end

    // Sticky flags: a new event wins over a clear in the same cycle.
    d.dc_flag = dc_hit || (q.dc_flag && !clear_all);
    d.oc_flag = (|oc_hits) || (q.oc_flag && !clear_all);
    d.short_flag = (q.state == amp_prot_pkg::ST_RUN && q.misc_s2[1]) ||
                   (q.short_flag && !clear_all);
    d.pin_flag = (q.state == amp_prot_pkg::ST_CHECK && q.misc_s2[0]) ||
                 (q.pin_flag && !clear_all);

    // Stage may run only with every supply up, no thermal error and no hard fault.
    run_ok = enabled && uv_ok && !d.te && !d.dc_flag && !d.pin_flag;

    // Sequencer.
    case (q.state)
      amp_prot_pkg::ST_OFF: begin
        d.timer = '0;
        if (run_ok) begin
          d.state = amp_prot_pkg::ST_CHECK;
        end
      end
      amp_prot_pkg::ST_CHECK: begin
        d.timer = q.timer + 18'h1;
        if (!run_ok) begin
          // A short seen here lands in pin_flag and blocks the start.
          d.state = amp_prot_pkg::ST_OFF;
        end else if (q.timer == PIN_LAST) begin
          d.state = amp_prot_pkg::ST_RUN;
        end
      end
      amp_prot_pkg::ST_RUN: begin
        d.timer = '0;
        if (!run_ok) begin
          d.state = amp_prot_pkg::ST_OFF;
        end else if ((|oc_hits) || q.misc_s2[1]) begin
          d.state = amp_prot_pkg::ST_HOLD;
        end
      end
      amp_prot_pkg::ST_HOLD: begin
        d.timer = (q.timer == RESTART_LAST) ? q.timer : q.timer + 18'h1;
        if (clear_all) begin
          d.state = amp_prot_pkg::ST_OFF;
        end else if (q.timer == RESTART_LAST && !q.ehctl[`EHCTL_NO_RESTART_BIT]) begin
          // Automatic restart unless software asked for a latched shutdown.
          d.state = amp_prot_pkg::ST_OFF;
        end
      end
      default: begin
        d.state = amp_prot_pkg::ST_OFF;
        d.timer = '0;
      end
    endcase

    d.stage_en = d.state == amp_prot_pkg::ST_RUN;
    // Limiting follows the threshold comparator only, never below it.
    d.cur_lim = |oc_hits;
    d.fault_n = !(d.tw || d.te || d.dc_flag || d.pin_flag ||
                  d.state == amp_prot_pkg::ST_HOLD);

    // Status byte as software sees it.
    status = '0;
    status[`STAT_OC_BIT] = q.oc_flag;
    status[`STAT_SHORT_BIT] = q.short_flag;
    status[`STAT_DC_BIT] = q.dc_flag;
    status[`STAT_PIN_BIT] = q.pin_flag;
    status[`STAT_TW_BIT] = q.tw;
    status[`STAT_TE_BIT] = q.te;
    status[`STAT_UV_BIT] = !(q.pv_ok && q.dv_ok && q.av_ok);

    // Reads answer two cycles after the strobe, after the memory's own register.
    d.rd_pend = reg_rd;
    d.rd_addr = reg_rd ? reg_addr : q.rd_addr;
    d.rvalid = q.rd_pend;
    if (q.rd_pend) begin
      if (q.rd_addr == `REG_DC_SHUTDOWN_CONTROL) begin
        d.rdata = q.dcctl;
      end else if (q.rd_addr == `REG_ERROR_HANDLER_CONTROL) begin
        d.rdata = q.ehctl;
      end else if (q.rd_addr == `REG_FAULT_STATUS) begin
        d.rdata = status;
      end else if (q.rd_addr <= `RW_LAST_ADDR) begin
        d.rdata = rb.rdata;
      end else begin
        // Unused read-only and gap entries read as zero.
        d.rdata = '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset leaves the stage off, supplies assumed low and DC protection on.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.state <= amp_prot_pkg::ST_OFF;
      q.dcctl <= `DCCTL_RESET;
      q.ehctl <= `EHCTL_RESET;
      q.misc_s1 <= 3'h4;
      q.misc_s2 <= 3'h4;
      q.fault_n <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign stage_enable = q.stage_en;
  assign current_limit = q.cur_lim;
  assign fault_n = q.fault_n;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  thermal_halt_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    q.te |-> !q.stage_en) else $error("stage switching during thermal error");

  thermal_fault_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (q.tw || q.te) |-> !q.fault_n) else $error("fault pin idle during thermal condition");

  te_hysteresis_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && q.te && temp_celsius > `TE_CLR_C) |=> q.te)
    else $error("thermal error cleared above its clear level");

  tw_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && temp_celsius >= `TW_SET_C) |=> q.tw)
    else $error("thermal warning not set at its set level");

  oc_shutdown_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && q.state == amp_prot_pkg::ST_RUN && run_ok && (|oc_hits))
    |=> (q.state == amp_prot_pkg::ST_HOLD && !q.stage_en && !q.fault_n && q.oc_flag))
    else $error("over-current did not latch a shutdown");

  auto_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && q.state == amp_prot_pkg::ST_HOLD && q.timer == RESTART_LAST &&
     !q.ehctl[`EHCTL_NO_RESTART_BIT]) |=> q.state == amp_prot_pkg::ST_OFF)
    else $error("no restart after current fault");

  pin_short_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && q.state == amp_prot_pkg::ST_CHECK && q.misc_s2[0])
    |=> (q.pin_flag && !q.stage_en) ##1 !q.stage_en)
    else $error("switching began into a pin short");

  dc_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(q.dc_flag) |-> $past(q.dcctl[`DCCTL_ENABLE_BIT]) && !q.stage_en && !q.fault_n)
    else $error("DC fault without enable or without shutdown");

  dc_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && clear_all && !dc_hit) |=> !q.dc_flag)
    else $error("DC fault survived a clear");

  uvlo_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !(q.pv_ok && q.dv_ok && q.av_ok) |-> !q.stage_en)
    else $error("stage switching under supply lockout");

  limit_cause_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && oc_hits == '0) |=> !q.cur_lim)
    else $error("current limiting below threshold");

  status_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && reg_rd && reg_addr >= `RO_FIRST_ADDR && reg_addr != `REG_FAULT_STATUS)
    ##1 clk_en |=> (q.rvalid && q.rdata == 8'h00))
    else $error("unused read-only entry did not read zero");

endmodule

`default_nettype wire

//--- testbench/mcu_model.sv
`default_nettype none

// ---------------------------------------------------------------
// Controller model on the register port
// ---------------------------------------------------------------
module mcu_model (
  input wire logic ref_clk,
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // The port is idle from time zero, so nothing is taken during reset.
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // A write stands for one edge; released lines show the inverse value.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // A read is taken at one edge; the answer stands for the cycle after the next edge.
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    #1;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

`default_nettype wire

//--- testbench/testbench.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, sys_rst, clk_en, enable_n, out_short_raw, pin_short_raw;
  logic [3:0] oc_raw, switch_on, dc_high_raw, dc_low_raw;
  logic [7:0] temp_celsius, power_stage_supply_dv, digital_supply_dv, analog_supply_dv, reg_wdata, reg_rdata, tv, d, a;
  logic [6:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, stage_enable, current_limit, fault_n, tw, te;
  int checks, n_fail, seed;

  amplifier_fault_protection #(.DC_QUAL_CYCLES(20), .RESTART_CYCLES(10)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .enable_n(enable_n),
    .oc_raw(oc_raw), .switch_on(switch_on), .out_short_raw(out_short_raw),
    .pin_short_raw(pin_short_raw), .dc_high_raw(dc_high_raw), .dc_low_raw(dc_low_raw),
    .temp_celsius(temp_celsius), .power_stage_supply_dv(power_stage_supply_dv), .digital_supply_dv(digital_supply_dv), .analog_supply_dv(analog_supply_dv),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .stage_enable(stage_enable),
    .current_limit(current_limit), .fault_n(fault_n));

  mcu_model i_mcu (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One comparison; a mismatch is reported and counted at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Reads a register and compares both the answer strobe and the byte.
  task automatic rchk(input logic [6:0] ad, input logic [7:0] exp);
    logic ok;
    i_mcu.rd(ad, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask

  // Bounded wait on the stage enable; running out ends the run as a failure.
  task automatic wst(input logic e, input int b);
    for (int i = 0; i < b && stage_enable !== e; i++) @(posedge ref_clk);
    chk({7'h00, stage_enable}, {7'h00, e});
    if (stage_enable !== e) end_sim();
  endtask

  // Expected thermal flag: set at or above on, cleared at or below off, else held.
  function automatic logic hyst(input logic s, input logic [7:0] t, on, off);
    if (t >= on) return 1'b1;
    if (t <= off) return 1'b0;
    return s;
  endfunction

  // Cycles the chip enable pin, which also drops latched faults.
  task automatic cyc_en();
    @(posedge ref_clk) enable_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    enable_n <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h49a7163d;
    {sys_rst, clk_en, enable_n} = 3'b111;
    {oc_raw, switch_on, dc_high_raw, dc_low_raw} = 16'h0000;
    {out_short_raw, pin_short_raw} = 2'b00;
    {temp_celsius, power_stage_supply_dv, digital_supply_dv, analog_supply_dv} = 32'h19000000;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rchk(7'h26, 8'h04);
    rchk(7'h2d, 8'h00);
    rchk(7'h7c, 8'h40);
    chk({7'h00, stage_enable}, 8'h00);
    // Power stage supply sits just below its rising level: stage must stay off.
    @(posedge ref_clk) {power_stage_supply_dv, digital_supply_dv, analog_supply_dv, enable_n} <= {24'h2a2a2a, 1'b0};
    repeat (300) @(posedge ref_clk);
    chk({7'h00, stage_enable}, 8'h00);
    power_stage_supply_dv <= 8'h2b;
    wst(1'b1, 300);
    rchk(7'h7c, 8'h00);
    digital_supply_dv <= 8'h29;
    repeat (10) @(posedge ref_clk);
    chk({7'h00, stage_enable}, 8'h01);
    digital_supply_dv <= 8'h28;
    wst(1'b0, 20);
    rchk(7'h7c, 8'h40);
    digital_supply_dv <= 8'h2a;
    wst(1'b1, 300);
    // Over-threshold on switches that are off must be ignored.
    oc_raw <= 4'hf;
    repeat (10) @(posedge ref_clk);
    chk({7'h00, stage_enable}, 8'h01);
    chk({7'h00, current_limit}, 8'h00);
    @(posedge ref_clk) {switch_on, oc_raw} <= {4'hf, 4'h0};
    repeat (10) @(posedge ref_clk);
    chk({7'h00, current_limit}, 8'h00);
    oc_raw <= 4'h1 << ($unsigned($random(seed)) % 4);
    wst(1'b0, 10);
    chk({7'h00, fault_n}, 8'h00);
    oc_raw <= 4'h0;
    wst(1'b1, 300);
    rchk(7'h7c, 8'h01);
    i_mcu.wr(7'h2d, 8'h04);
    rchk(7'h7c, 8'h00);
    // A pin short found before switching keeps the stage off until cleared.
    pin_short_raw <= 1'b1;
    cyc_en();
    repeat (400) @(posedge ref_clk);
    chk({7'h00, stage_enable}, 8'h00);
    rchk(7'h7c, 8'h08);
    pin_short_raw <= 1'b0;
    i_mcu.wr(7'h2d, 8'h00);
    wst(1'b1, 300);
    // An offset shorter than the qualification time is no fault.
    dc_high_raw <= 4'h2;
    repeat (15) @(posedge ref_clk);
    dc_high_raw <= 4'h0;
    repeat (30) @(posedge ref_clk);
    chk({7'h00, stage_enable}, 8'h01);
    dc_low_raw <= 4'h8;
    wst(1'b0, 40);
    chk({7'h00, fault_n}, 8'h00);
    dc_low_raw <= 4'h0;
    repeat (300) @(posedge ref_clk);
    chk({7'h00, stage_enable}, 8'h00);
    rchk(7'h7c, 8'h04);
    cyc_en();
    wst(1'b1, 300);
    i_mcu.wr(7'h26, 8'h00);
    dc_high_raw <= 4'h1;
    repeat (60) @(posedge ref_clk);
    chk({7'h00, stage_enable}, 8'h01);
    dc_high_raw <= 4'h0;
    i_mcu.wr(7'h26, 8'h04);
    // Read-only and unmapped places ignore writes; writable bytes keep data.
    i_mcu.wr(7'h7c, 8'hff);
    rchk(7'h7c, 8'h00);
    i_mcu.wr(7'h60, 8'ha5);
    rchk(7'h60, 8'h00);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h50 : 8'($unsigned($random(seed)) % 81);
      if (a == 8'h26 || a == 8'h2d) a = 8'h4f;
      tv = 8'($random(seed));
      i_mcu.wr(a[6:0], tv);
      rchk(a[6:0], tv);
    end
    // Random temperature walk against the hysteresis model.
    {tw, te} = 2'b00;
    for (int i = 0; i < 16; i++) begin
      tv = 8'h64 + 8'($unsigned($random(seed)) % 61);
      if (i < 6) tv = (i % 2) ? 8'h87 : 8'h96;
      @(posedge ref_clk) temp_celsius <= tv;
      tw = hyst(tw, tv, 8'h7d, 8'h69);
      te = hyst(te, tv, 8'h96, 8'h87);
      repeat (4) @(posedge ref_clk);
      rchk(7'h7c, {2'b00, te, tw, 4'h0});
      chk({7'h00, fault_n}, {7'h00, ~(tw | te)});
      if (te) chk({7'h00, stage_enable}, 8'h00);
    end
    temp_celsius <= 8'h50;
    wst(1'b1, 300);
    end_sim();
  end
endmodule

`default_nettype wire
